//--- core/cts_pkg.sv
// Shared constants, register map and carrier types of the timestamp block
package cts_pkg;
  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] OFF_CMD = 8'h00;
  localparam logic [7:0] OFF_CFG = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [7:0] OFF_TICK_HZ = 8'h0c;
  localparam logic [7:0] OFF_VAL_LO = 8'h10;
  localparam logic [7:0] OFF_VAL_HI = 8'h14;
  localparam logic [7:0] OFF_ROUTE = 8'h18;
  localparam logic [7:0] OFF_A1_KEY = 8'h1c;
  localparam logic [7:0] OFF_A1_FILT = 8'h20;
  localparam logic [7:0] OFF_A2_KEY = 8'h24;
  localparam logic [7:0] OFF_A2_FILT = 8'h28;
  localparam logic [7:0] OFF_ROLE = 8'h2c;

  // ==========================================================
  // Command bit positions and field widths
  localparam int CMD_LATCH_BIT = 0;
  localparam int CMD_CLEAR_BIT = 1;
  localparam int CFG_W = 7;
  localparam int ROUTE_W = 10;
  localparam int ROLE_W = 2;

  // ==========================================================
  // Reset values
  localparam logic [CFG_W-1:0] CFG_RST = 7'h00;
  localparam logic [ROUTE_W-1:0] ROUTE_RST = 10'h000;
  localparam logic [31:0] KEY_RST = 32'h0000_0000;
  localparam logic [31:0] FILT_RST = 32'hffff_ffff;
  localparam logic [ROLE_W-1:0] ROLE_RST = 2'h0;
  localparam logic [63:0] COUNT_RST = 64'h0000_0000_0000_0000;

  // ==========================================================
  // Tick rates per source, in Hz
  localparam logic [31:0] LOCAL_TICK_HZ = 32'h0098_9680;
  localparam logic [31:0] PTP_TICK_HZ = 32'h000f_4240;

  // ==========================================================
  // Bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================
  // Enumerations
  typedef enum logic {src_local_clock, src_ptp_clock} cts_src_t;
  typedef enum logic [1:0] {clr_none, input_one, input_two, action_two} cts_clr_src_t;
  typedef enum logic [1:0] {edge_fall, edge_rise, edge_either, edge_bad} cts_edge_t;
  typedef enum logic [1:0] {act_none, act_one, act_two, act_bad} cts_act_sel_t;
  typedef enum logic [1:0] {trg_line_start, trg_frame_start, trg_multi_frame, trg_other} cts_trg_t;

  // ==========================================================
  // Packed carriers
  typedef struct packed {
    cts_edge_t ts_clear_edge_mode;   // Edge of the clear line
    cts_clr_src_t ts_clear_source;   // Hardware clear source
    logic ts_capture_trigger;        // 1: latch at frame begin
    logic ptp_mode;                  // Precision-time mode on
    cts_src_t ts_increment_source;   // Requested count source
  } cts_cfg_t;

  typedef struct packed {
    cts_act_sel_t tmr_src;           // Timer start source
    cts_act_sel_t ctr_src;           // Counter start source
    cts_act_sel_t out_src;           // Output line pulse source
    cts_act_sel_t trig_src;          // Trigger source
    cts_trg_t trig_sel;              // Trigger selector
  } cts_route_t;

  typedef struct packed {
    logic valid;                     // One-cycle packet strobe
    logic [31:0] group_key;          // Group key in the packet
    logic [31:0] group_mask;         // Group mask in the packet
  } cts_act_pkt_t;
endpackage

//--- core/cts_line_edge.sv
// Two-stage synchroniser with edge detection for one input pin
`timescale 1ns/1ns
module cts_line_edge (
  input wire logic aclk,     // Block clock
  input wire logic aresetn,  // Synchronous reset, active low
  input wire logic pin,      // Asynchronous pin level
  output logic rise,         // One-cycle pulse on rising edge
  output logic fall          // One-cycle pulse on falling edge
);
  logic s1_ff;    // First stage, read by s2 only
  logic s2_ff;    // Settled level
  logic s3_ff;    // Previous settled level

  // ==========================================================
  // Synchroniser and history
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_ff <= 1'b0;
      s2_ff <= 1'b0;
      s3_ff <= 1'b0;
    end else begin
      s1_ff <= pin;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  // Edges seen on settled levels only
  assign rise = s2_ff && !s3_ff;
  assign fall = !s2_ff && s3_ff;
endmodule

//--- core/cts_action_match.sv
// Action packet filter producing one internal pulse per accepted packet
`timescale 1ns/1ns
module cts_action_match (
  input wire logic aclk,                     // Block clock
  input wire logic aresetn,                  // Synchronous reset, active low
  input wire cts_pkg::cts_act_pkt_t pkt,     // Received action packet
  input wire logic [31:0] match_key,         // Configured group key
  input wire logic [31:0] filter,            // Configured group mask
  input wire logic listen,                   // Role: 1 listens, 0 generates
  output logic pulse                         // One-cycle action pulse
);
  logic pulse_ff;    // Registered pulse
  wire key_ok = (pkt.group_key == match_key);           // Key equal
  wire mask_ok = |(pkt.group_mask & filter);            // Mask overlaps
  // listening role pulses once per matching packet
  // key and mask must both pass
  wire nxt_pulse = pkt.valid && listen && key_ok && mask_ok;

  // Pulse register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pulse_ff <= 1'b0;
    end else begin
      pulse_ff <= nxt_pulse;
    end
  end
  assign pulse = pulse_ff;

  a_match_cause: assert property (@(posedge aclk) disable iff (!aresetn)
    pulse |-> $past(pkt.valid) && $past(listen) && $past(key_ok) && $past(mask_ok))
    else $error("action pulse without an accepted packet");
  a_match_single: assert property (@(posedge aclk) disable iff (!aresetn)
    $past(pkt.valid && listen && key_ok && mask_ok) |-> pulse)
    else $error("accepted packet gave no pulse");
endmodule

//--- core/cts_timestamp.sv
// Timestamp counter with latch, clear sources, action routing and register slave
`timescale 1ns/1ns
module cts_timestamp (
  input wire logic aclk,                      // Block clock, 10 MHz
  input wire logic aresetn,                   // Synchronous reset, active low
  input wire logic [7:0] s_axi_awaddr,        // Write address
  input wire logic s_axi_awvalid,             // Write address valid
  output logic s_axi_awready,                 // Write address ready
  input wire logic [31:0] s_axi_wdata,        // Write data
  input wire logic [3:0] s_axi_wstrb,         // Write byte strobes
  input wire logic s_axi_wvalid,              // Write data valid
  output logic s_axi_wready,                  // Write data ready
  output logic [1:0] s_axi_bresp,             // Write response
  output logic s_axi_bvalid,                  // Write response valid
  input wire logic s_axi_bready,              // Write response ready
  input wire logic [7:0] s_axi_araddr,        // Read address
  input wire logic s_axi_arvalid,             // Read address valid
  output logic s_axi_arready,                 // Read address ready
  output logic [31:0] s_axi_rdata,            // Read data
  output logic [1:0] s_axi_rresp,             // Read response
  output logic s_axi_rvalid,                  // Read data valid
  input wire logic s_axi_rready,              // Read data ready
  input wire logic input_one_pin,             // Input line one, asynchronous
  input wire logic input_two_pin,             // Input line two, asynchronous
  input wire logic ptp_tick_pin,              // Precision clock tick, asynchronous
  input wire logic frame_begin,               // Frame start pulse, same clock
  input wire cts_pkg::cts_act_pkt_t act_pkt,  // Received action packet
  output logic trigger_pulse,                 // Action pulse to trigger logic
  output logic out_line_pulse,                // Action pulse to output line
  output logic counter_start_pulse,           // Action pulse to counter start
  output logic timer_start_pulse              // Action pulse to timer start
);
  // ==========================================================
  // Registers and state
  cts_pkg::cts_cfg_t cfg_ff;                  // Configuration
  cts_pkg::cts_route_t route_ff;              // Action routing
  logic [31:0] a1_key_ff;                     // Action one group key
  logic [31:0] a1_filt_ff;                    // Action one group mask
  logic [31:0] a2_key_ff;                     // Action two group key
  logic [31:0] a2_filt_ff;                    // Action two group mask
  logic [cts_pkg::ROLE_W-1:0] role_ff;        // Listen bits per action
  logic [63:0] local_cnt_ff;                  // Local-clock timer
  logic [63:0] ptp_cnt_ff;                    // Precision-clock timer
  logic [63:0] ts_latched_value_ff;           // Latched buffer
  logic bvalid_ff;                            // Write answer pending
  logic [1:0] bresp_ff;                       // Write answer code
  logic rvalid_ff;                            // Read answer pending
  logic [1:0] rresp_ff;                       // Read answer code
  logic [31:0] rdata_ff;                      // Read answer data
  logic [3:0] act_out_ff;                     // Routed action pulses

  // ==========================================================
  // Helpers
  // Byte-strobe merge of a write into a word
  function automatic logic [31:0] strb_merge(input logic [31:0] old, input logic [31:0] wd,
                                             input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) begin
        r[8*i +: 8] = wd[8*i +: 8];
      end
    end
    return r;
  endfunction

  // Pick an action pulse by routing selector
  function automatic logic act_pick(input cts_pkg::cts_act_sel_t sel, input logic a1,
                                    input logic a2);
    return (sel == cts_pkg::act_one) ? a1 : (sel == cts_pkg::act_two) ? a2 : 1'b0;
  endfunction

  // Pick the clearing edge of one line by edge mode; the spare code clears nothing
  function automatic logic edge_pick(input cts_pkg::cts_edge_t md, input logic r, input logic f);
    return (md == cts_pkg::edge_fall) ? f : (md == cts_pkg::edge_rise) ? r :
           (md == cts_pkg::edge_either) ? (r || f) : 1'b0;
  endfunction

  // ==========================================================
  // Pin synchronisers and action matchers
  logic l1_rise, l1_fall, l2_rise, l2_fall, ptp_rise;
  logic act1, act2;

  cts_line_edge u_line_one (.aclk(aclk), .aresetn(aresetn), .pin(input_one_pin),
    .rise(l1_rise), .fall(l1_fall));
  cts_line_edge u_line_two (.aclk(aclk), .aresetn(aresetn), .pin(input_two_pin),
    .rise(l2_rise), .fall(l2_fall));
  cts_line_edge u_ptp_tick (.aclk(aclk), .aresetn(aresetn), .pin(ptp_tick_pin),
    .rise(ptp_rise), .fall());

  cts_action_match u_act_one (.aclk(aclk), .aresetn(aresetn), .pkt(act_pkt),
    .match_key(a1_key_ff), .filter(a1_filt_ff), .listen(role_ff[0]), .pulse(act1));
  cts_action_match u_act_two (.aclk(aclk), .aresetn(aresetn), .pkt(act_pkt),
    .match_key(a2_key_ff), .filter(a2_filt_ff), .listen(role_ff[1]), .pulse(act2));

  // ==========================================================
  // Bus decode
  wire wr_go = s_axi_awvalid && s_axi_wvalid && !bvalid_ff;   // Write taken
  wire rd_go = s_axi_arvalid && !rvalid_ff;                   // Read taken
  wire wr_cmd = wr_go && (s_axi_awaddr == cts_pkg::OFF_CMD) && s_axi_wstrb[0];
  wire ts_latch_cmd = wr_cmd && s_axi_wdata[cts_pkg::CMD_LATCH_BIT];
  wire ts_clear_cmd = wr_cmd && s_axi_wdata[cts_pkg::CMD_CLEAR_BIT];

  // precision mode overrides the source selector
  wire cts_pkg::cts_src_t eff_src = cfg_ff.ptp_mode ? cts_pkg::src_ptp_clock
                                                    : cfg_ff.ts_increment_source;
  // current timestamp follows the effective source
  wire [63:0] ts_now = (eff_src == cts_pkg::src_ptp_clock) ? ptp_cnt_ff : local_cnt_ff;
  // tick rate of the active source
  wire [31:0] ts_ticks_per_second = (eff_src == cts_pkg::src_ptp_clock)
                                    ? cts_pkg::PTP_TICK_HZ : cts_pkg::LOCAL_TICK_HZ;

  // ==========================================================
  // Clear and latch decisions
  // edge choice on the selected line
  wire l1_hit = edge_pick(cfg_ff.ts_clear_edge_mode, l1_rise, l1_fall);
  wire l2_hit = edge_pick(cfg_ff.ts_clear_edge_mode, l2_rise, l2_fall);
  // action two clears when it is the source
  wire hw_clear = (cfg_ff.ts_clear_source == cts_pkg::input_one) ? l1_hit :
                  (cfg_ff.ts_clear_source == cts_pkg::input_two) ? l2_hit :
                  (cfg_ff.ts_clear_source == cts_pkg::action_two) ? act2 : 1'b0;
  // command clear independent of the source
  wire any_clear = hw_clear || ts_clear_cmd;
  // precision timer kept while precision mode runs
  wire ptp_clear = any_clear && !cfg_ff.ptp_mode;
  wire do_latch = ts_latch_cmd || (cfg_ff.ts_capture_trigger && frame_begin);

  // ==========================================================
  // Timers: clear beats increment
  // each timer counts its own clock; clear zeroes both, except the precision timer while precision mode is on
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      local_cnt_ff <= cts_pkg::COUNT_RST;
      ptp_cnt_ff <= cts_pkg::COUNT_RST;
    end else begin
      local_cnt_ff <= any_clear ? cts_pkg::COUNT_RST : local_cnt_ff + 64'h1;
      ptp_cnt_ff <= ptp_clear ? cts_pkg::COUNT_RST :
                    ptp_rise ? ptp_cnt_ff + 64'h1 : ptp_cnt_ff;
    end
  end

  // Latched buffer
  // buffer only changes on a latch
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ts_latched_value_ff <= cts_pkg::COUNT_RST;
    end else if (do_latch) begin
      ts_latched_value_ff <= ts_now;
    end
  end

  // ==========================================================
  // Action routing
  // trigger use only for start selectors
  wire trig_ok = (route_ff.trig_sel != cts_pkg::trg_other);
  // one action may feed all outputs; routes
  wire [3:0] nxt_act_out = {act_pick(route_ff.tmr_src, act1, act2),
                            act_pick(route_ff.ctr_src, act1, act2),
                            act_pick(route_ff.out_src, act1, act2),
                            trig_ok && act_pick(route_ff.trig_src, act1, act2)};

  // Routed pulse register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      act_out_ff <= 4'h0;
    end else begin
      act_out_ff <= nxt_act_out;
    end
  end
  assign trigger_pulse = act_out_ff[0];
  assign out_line_pulse = act_out_ff[1];
  assign counter_start_pulse = act_out_ff[2];
  assign timer_start_pulse = act_out_ff[3];

  // ==========================================================
  // Register writes
  wire wr_hit = (s_axi_awaddr == cts_pkg::OFF_CMD) || (s_axi_awaddr == cts_pkg::OFF_CFG) ||
                (s_axi_awaddr == cts_pkg::OFF_ROUTE) || (s_axi_awaddr == cts_pkg::OFF_A1_KEY) ||
                (s_axi_awaddr == cts_pkg::OFF_A1_FILT) || (s_axi_awaddr == cts_pkg::OFF_A2_KEY) ||
                (s_axi_awaddr == cts_pkg::OFF_A2_FILT) || (s_axi_awaddr == cts_pkg::OFF_ROLE);
  wire [31:0] cfg_word = strb_merge({25'h0, cfg_ff}, s_axi_wdata, s_axi_wstrb);
  wire [31:0] route_word = strb_merge({22'h0, route_ff}, s_axi_wdata, s_axi_wstrb);
  wire [31:0] role_word = strb_merge({30'h0, role_ff}, s_axi_wdata, s_axi_wstrb);

  // Writable configuration
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_ff <= cts_pkg::cts_cfg_t'(cts_pkg::CFG_RST);
      route_ff <= cts_pkg::cts_route_t'(cts_pkg::ROUTE_RST);
      a1_key_ff <= cts_pkg::KEY_RST;
      a1_filt_ff <= cts_pkg::FILT_RST;
      a2_key_ff <= cts_pkg::KEY_RST;
      a2_filt_ff <= cts_pkg::FILT_RST;
      role_ff <= cts_pkg::ROLE_RST;
    end else if (wr_go) begin
      unique case (s_axi_awaddr)
        cts_pkg::OFF_CFG: cfg_ff <= cts_pkg::cts_cfg_t'(cfg_word[cts_pkg::CFG_W-1:0]);
        cts_pkg::OFF_ROUTE: route_ff <= cts_pkg::cts_route_t'(route_word[cts_pkg::ROUTE_W-1:0]);
        cts_pkg::OFF_A1_KEY: a1_key_ff <= strb_merge(a1_key_ff, s_axi_wdata, s_axi_wstrb);
        cts_pkg::OFF_A1_FILT: a1_filt_ff <= strb_merge(a1_filt_ff, s_axi_wdata, s_axi_wstrb);
        cts_pkg::OFF_A2_KEY: a2_key_ff <= strb_merge(a2_key_ff, s_axi_wdata, s_axi_wstrb);
        cts_pkg::OFF_A2_FILT: a2_filt_ff <= strb_merge(a2_filt_ff, s_axi_wdata, s_axi_wstrb);
        cts_pkg::OFF_ROLE: role_ff <= role_word[cts_pkg::ROLE_W-1:0];
        default: ;
      endcase
    end
  end

  // Write answer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_ff <= 1'b0;
      bresp_ff <= cts_pkg::RESP_OKAY;
    end else if (wr_go) begin
      bvalid_ff <= 1'b1;
      bresp_ff <= wr_hit ? cts_pkg::RESP_OKAY : cts_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_ff <= 1'b0;
    end
  end
  assign s_axi_awready = wr_go;
  assign s_axi_wready = wr_go;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;

  // ==========================================================
  // Register reads
  wire [31:0] rd_mux =
    (s_axi_araddr == cts_pkg::OFF_CMD) ? 32'h0000_0000 :
    (s_axi_araddr == cts_pkg::OFF_CFG) ? {25'h0, cfg_ff} :
    (s_axi_araddr == cts_pkg::OFF_STATUS) ? {31'h0, eff_src} :
    (s_axi_araddr == cts_pkg::OFF_TICK_HZ) ? ts_ticks_per_second :
    (s_axi_araddr == cts_pkg::OFF_VAL_LO) ? ts_latched_value_ff[31:0] :
    (s_axi_araddr == cts_pkg::OFF_VAL_HI) ? ts_latched_value_ff[63:32] :
    (s_axi_araddr == cts_pkg::OFF_ROUTE) ? {22'h0, route_ff} :
    (s_axi_araddr == cts_pkg::OFF_A1_KEY) ? a1_key_ff :
    (s_axi_araddr == cts_pkg::OFF_A1_FILT) ? a1_filt_ff :
    (s_axi_araddr == cts_pkg::OFF_A2_KEY) ? a2_key_ff :
    (s_axi_araddr == cts_pkg::OFF_A2_FILT) ? a2_filt_ff :
    (s_axi_araddr == cts_pkg::OFF_ROLE) ? {30'h0, role_ff} : 32'h0000_0000;
  wire rd_hit = (s_axi_araddr <= cts_pkg::OFF_ROLE) && (s_axi_araddr[1:0] == 2'h0);

  // Read answer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_ff <= 1'b0;
      rresp_ff <= cts_pkg::RESP_OKAY;
      rdata_ff <= 32'h0000_0000;
    end else if (rd_go) begin
      rvalid_ff <= 1'b1;
      rresp_ff <= rd_hit ? cts_pkg::RESP_OKAY : cts_pkg::RESP_SLVERR;
      rdata_ff <= rd_mux;
    end else if (s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end
  assign s_axi_arready = rd_go;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rresp = rresp_ff;
  assign s_axi_rdata = rdata_ff;

  // ==========================================================
  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_latch_req;
    do_latch ##0 (ts_now == ts_now);
  endsequence

  a_latch_copy: assert property (s_latch_req |=> ts_latched_value_ff == $past(ts_now))
    else $error("latch did not copy the counter");
  a_buffer_hold: assert property (!do_latch |=> $stable(ts_latched_value_ff))
    else $error("buffer changed without a latch");
  a_ptp_forced: assert property (cfg_ff.ptp_mode |-> eff_src == cts_pkg::src_ptp_clock)
    else $error("precision mode did not force the source");
  a_tick_rate: assert property (eff_src == cts_pkg::src_local_clock
    |-> ts_ticks_per_second == cts_pkg::LOCAL_TICK_HZ)
    else $error("tick rate does not match the local source");
  a_frame_latch: assert property (cfg_ff.ts_capture_trigger && frame_begin
    |=> ts_latched_value_ff == $past(ts_now))
    else $error("frame begin did not latch");
  a_cmd_clear: assert property (ts_clear_cmd |=> local_cnt_ff == 64'h0)
    else $error("clear command left the local timer");
  a_ptp_keep: assert property (ts_clear_cmd && cfg_ff.ptp_mode && !ptp_rise
    |=> ptp_cnt_ff == $past(ptp_cnt_ff))
    else $error("precision timer cleared while mode on");
  a_action_clear: assert property (act2 && cfg_ff.ts_clear_source == cts_pkg::action_two
    |=> local_cnt_ff == 64'h0)
    else $error("action two did not clear");
  a_trig_gate: assert property (trigger_pulse |-> $past(trig_ok))
    else $error("trigger pulse with a refused selector");
endmodule

//--- dv/cts_host_model.sv
// Host-side broadcaster of action packets
`timescale 1ns/1ns
module cts_host_model (
  input wire logic aclk,                 // Block clock
  output cts_pkg::cts_act_pkt_t act_pkt  // Packet seen by the camera
);
  initial act_pkt = '0;
  task automatic send(input logic [31:0] k, input logic [31:0] m);
    @(posedge aclk);
    act_pkt <= {1'b1, k, m};
    @(posedge aclk);
    act_pkt <= {1'b0, ~k, ~m};
  endtask
endmodule

//--- dv/cts_timestamp_tb_top.sv
// Self-checking bench of the timestamp block
`timescale 1ns/1ns
module cts_timestamp_tb_top;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic input_one_pin, input_two_pin, ptp_tick_pin, frame_begin, s_axi_awready, s_axi_wready;
  logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, trigger_pulse, out_line_pulse;
  logic counter_start_pulse, timer_start_pulse;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, v1, t0;
  logic [1:0] s_axi_bresp, s_axi_rresp, bq;
  logic [3:0] s_axi_wstrb;
  cts_pkg::cts_act_pkt_t act_pkt;
  int err_total, n_compared, npul, cyc, c0, c1;
  // Rows: config word, read address, expected word
  logic [31:0] rows [6][3] = '{'{0, 12, 32'h0098_9680}, '{2, 8, 1}, '{2, 12, 32'h000f_4240},
    '{1, 8, 1}, '{1, 12, 32'h000f_4240}, '{0, 8, 0}};
  cts_timestamp cts_timestamp_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .input_one_pin, .input_two_pin, .ptp_tick_pin,
    .frame_begin, .act_pkt, .trigger_pulse, .out_line_pulse, .counter_start_pulse,
    .timer_start_pulse);
  cts_host_model cts_host_model_inst (.aclk, .act_pkt);
  // 100 ns clock
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  // Cycle and action pulse tallies
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (aresetn) npul <= npul + trigger_pulse + out_line_pulse + counter_start_pulse
                         + timer_start_pulse;
  end
  // Bus write, both channels offered together
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {a, d, 3'h7};
    do @(negedge aclk); while (s_axi_awready !== 1'b1);
    @(posedge aclk);
    {s_axi_awvalid, s_axi_wvalid} <= 2'h0;
    do @(negedge aclk); while (s_axi_bvalid !== 1'b1);
    bq = s_axi_bresp;
    @(posedge aclk);
    s_axi_bready <= 1'b0;
  endtask
  // Bus read
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
    do @(negedge aclk); while (s_axi_arready !== 1'b1);
    @(posedge aclk);
    s_axi_arvalid <= 1'b0;
    do @(negedge aclk); while (s_axi_rvalid !== 1'b1);
    {v1, bq} = {s_axi_rdata, s_axi_rresp};
    @(posedge aclk);
    s_axi_rready <= 1'b0;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic latch_read;
    wr(cts_pkg::OFF_CMD, 32'h1);
    rd(cts_pkg::OFF_VAL_LO);
  endtask
  task automatic test_done;
    $display("compared %0d errors %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Watchdog against a hung handshake
  initial begin
    repeat (30000) @(posedge aclk);
    err_total++;
    test_done;
  end
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {input_one_pin, input_two_pin, ptp_tick_pin, frame_begin, s_axi_awaddr, s_axi_araddr} = '0;
    {s_axi_wdata, s_axi_wstrb} = {32'h0, 4'hf};
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    rd(cts_pkg::OFF_A1_FILT);
    chk("filt_rst", 32'hffff_ffff, v1);
    for (int i = 0; i < 6; i++) begin
      wr(cts_pkg::OFF_CFG, rows[i][0]);
      rd(rows[i][1][7:0]);
      chk("row", rows[i][2], v1);
    end
    rd(8'h40);
    chk("unmapped", {30'h0, cts_pkg::RESP_SLVERR}, {30'h0, bq});
    wr(8'h40, 32'h0);
    chk("wr_unmapped", {30'h0, cts_pkg::RESP_SLVERR}, {30'h0, bq});
    wr(cts_pkg::OFF_CMD, 32'h2);
    latch_read;
    chk("clear", 32'h1, {31'h0, v1 < 32'd40});
    t0 = v1;
    repeat (100) @(posedge aclk);
    rd(cts_pkg::OFF_VAL_LO);
    chk("hold", t0, v1);
    latch_read;
    chk("step", 32'h1, {31'h0, v1 - t0 > 32'd100 && v1 - t0 < 32'd160});
    rd(cts_pkg::OFF_VAL_HI);
    chk("hi", 32'h0, v1);
    wr(cts_pkg::OFF_CFG, 32'h4);
    for (int f = 0; f < 2; f++) begin
      @(posedge aclk);
      frame_begin <= 1'b1;
      {c0, c1} = {c1, cyc};
      @(posedge aclk);
      frame_begin <= 1'b0;
      rd(cts_pkg::OFF_VAL_LO);
      if (f == 0) t0 = v1;
    end
    // Two frame latches lie as many counts apart as the pulses lie cycles apart
    chk("frame", c1 - c0, v1 - t0);
    // Edge mode by clear line and direction, spare mode included
    for (int m = 0; m < 4; m++) for (int l = 1; l < 3; l++) for (int d = 0; d < 2; d++) begin
      wr(cts_pkg::OFF_CFG, (m << 5) | (l << 3));
      repeat (100) @(posedge aclk);
      if (l == 1) input_one_pin <= ~input_one_pin;
      else input_two_pin <= ~input_two_pin;
      repeat (10) @(posedge aclk);
      latch_read;
      chk("edge", {31'h0, m == 2 || (m < 2 && m != d)}, {31'h0, v1 < 32'd40});
    end
    wr(cts_pkg::OFF_CFG, 32'h3);
    for (int k = 0; k < 10; k++) begin
      @(posedge aclk);
      ptp_tick_pin <= ~ptp_tick_pin;
      repeat (4) @(posedge aclk);
    end
    wr(cts_pkg::OFF_CMD, 32'h2);
    latch_read;
    chk("ptp_kept", 32'h5, v1);
    wr(cts_pkg::OFF_CFG, 32'h1);
    wr(cts_pkg::OFF_CMD, 32'h2);
    latch_read;
    chk("ptp_clr", 32'h0, v1);
    wr(cts_pkg::OFF_ROLE, 32'h3);
    wr(cts_pkg::OFF_A1_KEY, 32'h12);
    wr(cts_pkg::OFF_A2_KEY, 32'h34);
    for (int r = 0; r < 4; r++) begin
      wr(cts_pkg::OFF_ROUTE, r == 3 ? 32'h157 : 32'h154);
      cts_host_model_inst.send(32'h12 + (r == 1), {31'h0, r != 2});
      repeat (5) @(posedge aclk);
      chk("pulses", r == 0 ? 32'h4 : r == 3 ? 32'h7 : 32'h4, npul);
    end
    wr(cts_pkg::OFF_CFG, 32'h18);
    repeat (100) @(posedge aclk);
    cts_host_model_inst.send(32'h34, 32'h1);
    latch_read;
    chk("act_clr", 32'h1, {31'h0, v1 < 32'd40});
    // Mid-run reset brings configuration and buffer back to zero
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(cts_pkg::OFF_CFG);
    chk("cfg_rst", 32'h0, v1);
    rd(cts_pkg::OFF_VAL_LO);
    chk("val_rst", 32'h0, v1);
    test_done;
  end
endmodule
